// *** include/pd_task_params.svh ***
// constants for the capability task interpreter: codes, offsets, timing
// assumes one 40 MHz clock and a policy engine on the same clock
`ifndef PD_TASK_PARAMS_SVH
`define PD_TASK_PARAMS_SVH

// four-character task codes, first character in the top byte
`define TASK_GET_SNK_CAPS   32'h47536b43
`define TASK_GET_SRC_CAPS   32'h47537243
`define TASK_SEND_SRC_CAPS  32'h53537243

// task return codes
`define RC_SUCCESS          8'h00
`define RC_TIMEOUT          8'h01
`define RC_REJECTED         8'h02
`define RC_UNKNOWN          8'h03

// offsets of the received capability stores
`define OFS_RX_SRC_CAPS     8'h30
`define OFS_RX_SNK_CAPS     8'h31

// clock and partner response time
`define CLK_PERIOD_NS       25
`define RESP_TIME_US        30000
`define RESP_CYCLES         ((`RESP_TIME_US * 1000) / `CLK_PERIOD_NS)

`define MAX_OBJS            7

`endif

// *** include/pd_task_pkg.sv ***
// types shared by the capability task interpreter
// assumes pd_task_params.svh is compiled alongside
package pd_task_pkg;

  typedef enum logic [3:0] {
    MSG_NONE         = 4'h0,
    MSG_GET_SNK_CAP  = 4'h1,
    MSG_GET_SRC_CAP  = 4'h2,
    MSG_SRC_CAPS     = 4'h3,
    MSG_SNK_CAPS     = 4'h4,
    MSG_REJECT       = 4'h5,
    MSG_NOT_SUPP     = 4'h6,
    MSG_OTHER        = 4'hf
  } msg_t;

  typedef struct packed {
    logic       valid;
    msg_t       kind;
  } tx_req_t;

  typedef struct packed {
    logic       valid;
    msg_t       kind;
    logic [2:0] nobj;
  } rx_msg_t;

  typedef struct packed {
    logic        valid;
    logic [2:0]  idx;
    logic [31:0] data;
  } rx_obj_t;

endpackage

// *** src/resp_timer.sv ***
// one-shot response timer for the capability task interpreter
// assumes start and stop come from logic on the same clock
`timescale 1ns/1ps
module resp_timer
  import pd_task_pkg::*;
#(
  parameter int unsigned CYCLES = 1200000
)(
  input  wire logic CLK,
  input  wire logic RST_N,
  input  wire logic START,
  input  wire logic STOP,
  output logic      EXPIRED
);

  logic [31:0] cnt_r;
  logic [31:0] cnt_nxt;
  logic        run_r;
  logic        run_nxt;
  logic        exp_r;
  logic        exp_nxt;

  always_comb
  begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    exp_nxt = 1'b0;
    if (START)
    begin
      cnt_nxt = CYCLES - 32'h1;
      run_nxt = 1'b1;
    end
    else if (STOP)
      run_nxt = 1'b0;
    else if (run_r)
    begin
      if (cnt_r == 32'h0)
      begin
        run_nxt = 1'b0;
        exp_nxt = 1'b1;
      end
      else
        cnt_nxt = cnt_r - 32'h1;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cnt_r <= 32'h0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
      exp_r <= exp_nxt;
    end
  end

  assign EXPIRED = exp_r;

endmodule // resp_timer

// *** src/pd_cap_tasks.sv ***
// capability task interpreter: three host tasks driving pd messages
// assumes host and policy engine sit on the same clock as this block
`timescale 1ns/1ps
`include "pd_task_params.svh"
module pd_cap_tasks
  import pd_task_pkg::*;
#(
  parameter int unsigned RESP_CYC = `RESP_CYCLES,
  parameter int unsigned NOBJ     = `MAX_OBJS
)(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        TASK_VALID,
  input  wire logic [31:0] TASK_CODE,
  output logic             TASK_READY,
  output logic             TASK_DONE,
  output logic [7:0]       RET_CODE,
  input  wire logic        PARTNER_IS_SRC,
  input  wire logic        PARTNER_NOT_DRP,
  input  wire logic        OWN_ROLE_SRC,
  input  wire logic        PE_READY,
  output tx_req_t          TX_REQ,
  input  wire logic        TX_GOODCRC,
  input  wire logic        TX_NO_ACK,
  input  wire rx_msg_t     RX_MSG,
  input  wire rx_obj_t     RX_OBJ,
  output logic             NEGOTIATE_REQ,
  input  wire logic [7:0]  CAPS_OFS,
  input  wire logic [2:0]  CAPS_IDX,
  output logic [31:0]      CAPS_WORD,
  output logic [2:0]       SRC_CAPS_CNT,
  output logic [2:0]       SNK_CAPS_CNT
);

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_OPP  = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_RESP = 5'b01000,
    ST_DONE = 5'b10000
  } state_t;

  typedef enum logic [1:0] {
    TK_SNK  = 2'h0,
    TK_SRC  = 2'h1,
    TK_SEND = 2'h2
  } task_t;

  state_t      state_r;
  state_t      state_nxt;
  task_t       task_r;
  task_t       task_nxt;
  logic [7:0]  ret_r;
  logic [7:0]  ret_nxt;
  logic        neg_r;
  logic        neg_nxt;
  logic        tmr_start;
  logic        tmr_stop;
  logic        tmr_exp;
  logic        commit;
  logic [31:0] stage_r [NOBJ];
  logic [31:0] stage_nxt [NOBJ];
  logic [31:0] src_store_r [NOBJ];
  logic [31:0] src_store_nxt [NOBJ];
  logic [31:0] snk_store_r [NOBJ];
  logic [31:0] snk_store_nxt [NOBJ];
  logic [2:0]  src_cnt_r;
  logic [2:0]  src_cnt_nxt;
  logic [2:0]  snk_cnt_r;
  logic [2:0]  snk_cnt_nxt;
  logic [31:0] caps_word_r;
  logic [31:0] caps_word_nxt;

  function automatic msg_t request_of(input task_t t);
    unique case (t)
      TK_SNK:  request_of = MSG_GET_SNK_CAP;
      TK_SRC:  request_of = MSG_GET_SRC_CAP;
      default: request_of = MSG_SRC_CAPS;
    endcase
  endfunction

  function automatic msg_t reply_of(input task_t t);
    reply_of = (t == TK_SNK) ? MSG_SNK_CAPS : MSG_SRC_CAPS;
  endfunction

  function automatic logic is_refusal(input msg_t m);
    is_refusal = (m == MSG_REJECT) || (m == MSG_NOT_SUPP);
  endfunction

  resp_timer #(
    .CYCLES (RESP_CYC)
  ) u_timer (
    .CLK     (CLK),
    .RST_N   (RST_N),
    .START   (tmr_start),
    .STOP    (tmr_stop),
    .EXPIRED (tmr_exp)
  );

  // task sequencer
  always_comb
  begin
    state_nxt = state_r;
    task_nxt  = task_r;
    ret_nxt   = ret_r;
    neg_nxt   = 1'b0;
    tmr_start = 1'b0;
    tmr_stop  = 1'b0;
    commit    = 1'b0;
    TX_REQ    = '{valid: 1'b0, kind: MSG_NONE};
    unique case (state_r)
      ST_IDLE:
      begin
        if (TASK_VALID)
        begin
          state_nxt = ST_OPP;
          if (TASK_CODE == `TASK_GET_SNK_CAPS)
          begin
            task_nxt = TK_SNK;
            if (PARTNER_IS_SRC && PARTNER_NOT_DRP)
            begin
              ret_nxt   = `RC_REJECTED;
              state_nxt = ST_DONE;
            end
          end
          else if (TASK_CODE == `TASK_GET_SRC_CAPS)
          begin
            task_nxt = TK_SRC;
            if (!PARTNER_IS_SRC && PARTNER_NOT_DRP)
            begin
              ret_nxt   = `RC_REJECTED;
              state_nxt = ST_DONE;
            end
          end
          else if (TASK_CODE == `TASK_SEND_SRC_CAPS)
          begin
            task_nxt = TK_SEND;
            if (!OWN_ROLE_SRC)
            begin
              ret_nxt   = `RC_REJECTED;
              state_nxt = ST_DONE;
            end
          end
          else
          begin
            ret_nxt   = `RC_UNKNOWN;
            state_nxt = ST_DONE;
          end
        end
      end
      ST_OPP:
      begin
        if (PE_READY)
        begin
          TX_REQ    = '{valid: 1'b1, kind: request_of(task_r)};
          state_nxt = ST_ACK;
        end
      end
      ST_ACK:
      begin
        if (TX_GOODCRC)
        begin
          if (task_r == TK_SEND)
          begin
            ret_nxt   = `RC_SUCCESS;
            neg_nxt   = 1'b1;
            state_nxt = ST_DONE;
          end
          else
          begin
            tmr_start = 1'b1;
            state_nxt = ST_RESP;
          end
        end
        else if (TX_NO_ACK)
        begin
          ret_nxt   = `RC_TIMEOUT;
          state_nxt = ST_DONE;
        end
      end
      ST_RESP:
      begin
        if (RX_MSG.valid && RX_MSG.kind == reply_of(task_r))
        begin
          commit    = 1'b1;
          tmr_stop  = 1'b1;
          ret_nxt   = `RC_SUCCESS;
          state_nxt = ST_DONE;
        end
        else if (RX_MSG.valid && is_refusal(RX_MSG.kind))
        begin
          tmr_stop  = 1'b1;
          ret_nxt   = `RC_REJECTED;
          state_nxt = ST_DONE;
        end
        else if (tmr_exp)
        begin
          ret_nxt   = `RC_TIMEOUT;
          state_nxt = ST_DONE;
        end
      end
      ST_DONE:
        state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_r <= ST_IDLE;
      task_r  <= TK_SNK;
      ret_r   <= `RC_SUCCESS;
      neg_r   <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      task_r  <= task_nxt;
      ret_r   <= ret_nxt;
      neg_r   <= neg_nxt;
    end
  end

  // capability staging and stores
  always_comb
  begin
    stage_nxt     = stage_r;
    src_store_nxt = src_store_r;
    snk_store_nxt = snk_store_r;
    src_cnt_nxt   = src_cnt_r;
    snk_cnt_nxt   = snk_cnt_r;
    if (RX_OBJ.valid && RX_OBJ.idx < NOBJ[2:0])
      stage_nxt[RX_OBJ.idx] = RX_OBJ.data;
    if (commit && task_r == TK_SNK)
    begin
      snk_store_nxt = stage_r;
      snk_cnt_nxt   = RX_MSG.nobj;
    end
    if (commit && task_r == TK_SRC)
    begin
      src_store_nxt = stage_r;
      src_cnt_nxt   = RX_MSG.nobj;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      for (int i = 0; i < NOBJ; i++)
      begin
        stage_r[i]     <= 32'h0;
        src_store_r[i] <= 32'h0;
        snk_store_r[i] <= 32'h0;
      end
      src_cnt_r <= 3'h0;
      snk_cnt_r <= 3'h0;
    end
    else
    begin
      stage_r     <= stage_nxt;
      src_store_r <= src_store_nxt;
      snk_store_r <= snk_store_nxt;
      src_cnt_r   <= src_cnt_nxt;
      snk_cnt_r   <= snk_cnt_nxt;
    end
  end

  // store read port
  always_comb
  begin
    caps_word_nxt = 32'h0;
    if (CAPS_IDX < NOBJ[2:0])
    begin
      if (CAPS_OFS == `OFS_RX_SRC_CAPS)
        caps_word_nxt = src_store_r[CAPS_IDX];
      else if (CAPS_OFS == `OFS_RX_SNK_CAPS)
        caps_word_nxt = snk_store_r[CAPS_IDX];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      caps_word_r <= 32'h0;
    else
      caps_word_r <= caps_word_nxt;
  end

  assign TASK_READY    = (state_r == ST_IDLE);
  assign TASK_DONE     = (state_r == ST_DONE);
  assign RET_CODE      = ret_r;
  assign NEGOTIATE_REQ = neg_r;
  assign CAPS_WORD     = caps_word_r;
  assign SRC_CAPS_CNT  = src_cnt_r;
  assign SNK_CAPS_CNT  = snk_cnt_r;

  // checks
  sequence s_accept(logic [31:0] code);
    state_r == ST_IDLE && TASK_VALID && TASK_CODE == code;
  endsequence

  sequence s_done_with(logic [7:0] rc);
    state_r == ST_DONE && RET_CODE == rc;
  endsequence

  chk_snk_drp_reject: assert property (@(posedge CLK) disable iff (!RST_N)
    s_accept(`TASK_GET_SNK_CAPS) and (PARTNER_IS_SRC && PARTNER_NOT_DRP)
      |=> s_done_with(`RC_REJECTED))
    else $error("sink request not rejected for non-drp source");

  chk_src_drp_reject: assert property (@(posedge CLK) disable iff (!RST_N)
    s_accept(`TASK_GET_SRC_CAPS) and (!PARTNER_IS_SRC && PARTNER_NOT_DRP)
      |=> s_done_with(`RC_REJECTED))
    else $error("source request not rejected for non-drp sink");

  chk_role_reject: assert property (@(posedge CLK) disable iff (!RST_N)
    s_accept(`TASK_SEND_SRC_CAPS) and !OWN_ROLE_SRC |=> s_done_with(`RC_REJECTED))
    else $error("send caps not rejected outside source role");

  chk_send_on_opp: assert property (@(posedge CLK) disable iff (!RST_N)
    state_r == ST_OPP && PE_READY |-> TX_REQ.valid ##1 state_r == ST_ACK)
    else $error("request not sent at opportunity");

  chk_refusal_reject: assert property (@(posedge CLK) disable iff (!RST_N)
    state_r == ST_RESP && RX_MSG.valid && is_refusal(RX_MSG.kind)
      && RX_MSG.kind != reply_of(task_r) |=> s_done_with(`RC_REJECTED))
    else $error("refusal reply not reported as rejected");

  chk_snk_commit: assert property (@(posedge CLK) disable iff (!RST_N)
    state_r == ST_RESP && task_r == TK_SNK && RX_MSG.valid && RX_MSG.kind == MSG_SNK_CAPS
      |=> SNK_CAPS_CNT == $past(RX_MSG.nobj) and s_done_with(`RC_SUCCESS))
    else $error("sink caps store not updated on success");

  chk_ack_success: assert property (@(posedge CLK) disable iff (!RST_N)
    state_r == ST_ACK && task_r == TK_SEND && TX_GOODCRC
      |=> s_done_with(`RC_SUCCESS) and NEGOTIATE_REQ)
    else $error("acknowledged caps not reported as success");

  chk_noack_timeout: assert property (@(posedge CLK) disable iff (!RST_N)
    state_r == ST_ACK && !TX_GOODCRC && TX_NO_ACK |=> s_done_with(`RC_TIMEOUT))
    else $error("unacknowledged message not timed out");

  chk_resp_timeout: assert property (@(posedge CLK) disable iff (!RST_N)
    state_r == ST_RESP && tmr_exp && !RX_MSG.valid |=> s_done_with(`RC_TIMEOUT))
    else $error("missing reply not timed out");

  chk_success_path: assert property (@(posedge CLK) disable iff (!RST_N)
    s_done_with(`RC_SUCCESS) and task_r != TK_SEND |-> $past(state_r) == ST_RESP)
    else $error("get task succeeded without a reply");

endmodule // pd_cap_tasks

// *** test/pd_link_model.sv ***
// partner model: policy engine and port partner behind the link port
// assumes one clock; the bench sets the reply for each task
`timescale 1ns/1ps
module pd_link_model
  import pd_task_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hold_pe,
  input  wire logic        ack_ok,
  input  wire logic [3:0]  ack_dly,
  input  wire msg_t        reply,
  input  wire logic [2:0]  nobj,
  input  wire logic [15:0] salt,
  input  wire tx_req_t     tx_req,
  output logic             pe_ready,
  output logic             goodcrc,
  output logic             no_ack,
  output rx_msg_t          rx_msg,
  output rx_obj_t          rx_obj,
  output msg_t             last_tx,
  output logic [7:0]       tx_cnt,
  output logic             early_tx
);
  assign pe_ready = !hold_pe;
  always @(posedge clk)
  begin
    if (tx_req.valid === 1'b1 && hold_pe)
      early_tx <= 1'b1;
  end
  initial
  begin
    goodcrc  = 1'b0;
    no_ack   = 1'b0;
    rx_msg   = '0;
    rx_obj   = '0;
    last_tx  = MSG_NONE;
    tx_cnt   = 8'h00;
    early_tx = 1'b0;
    forever
    begin
      // request taken at the edge where the design moves on
      @(posedge clk);
      if (tx_req.valid === 1'b1)
      begin
        last_tx = tx_req.kind;
        tx_cnt  = tx_cnt + 8'h01;
        repeat (ack_dly + 1) @(negedge clk);
        // ack pulse, or sent without acknowledgement
        goodcrc = ack_ok;
        no_ack  = !ack_ok;
        @(negedge clk);
        goodcrc = 1'b0;
        no_ack  = 1'b0;
        if (ack_ok && reply != MSG_NONE)
        begin
          for (int i = 0; i < nobj; i++)
          begin
            rx_obj = '{1'b1, i[2:0], {salt, 13'h0000, i[2:0]}};
            @(negedge clk);
          end
          // released data line shows no stale word
          rx_obj.valid = 1'b0;
          rx_obj.data  = ~rx_obj.data;
          rx_msg = '{1'b1, reply, nobj};
          @(negedge clk);
          rx_msg = '0;
        end
      end
    end
  end
endmodule // pd_link_model

// *** test/test_pd_cap_tasks.sv ***
// self-checking bench for the capability task interpreter
// assumes pd_link_model stands in for policy engine and port partner
`timescale 1ns/1ps
`include "pd_task_params.svh"
module test_pd_cap_tasks
  import pd_task_pkg::*;
;
  typedef struct packed {
    logic [31:0] code;
    logic        src, ndrp, own, ack;
    msg_t        reply;
    logic [2:0]  n;
    logic [7:0]  ret;
    msg_t        tx;
  } row_t;
  localparam logic [31:0] SK = `TASK_GET_SNK_CAPS;
  localparam logic [31:0] SR = `TASK_GET_SRC_CAPS;
  localparam logic [31:0] SS = `TASK_SEND_SRC_CAPS;
  localparam logic [7:0]  OK = `RC_SUCCESS;
  localparam logic [7:0]  TO = `RC_TIMEOUT;
  localparam logic [7:0]  RJ = `RC_REJECTED;
  row_t rows [14] = '{
    '{SK, 1, 1, 1, 1, MSG_SNK_CAPS, 0, RJ, MSG_NONE},
    '{SK, 0, 1, 1, 1, MSG_SNK_CAPS, 3, OK, MSG_GET_SNK_CAP},
    '{SK, 1, 0, 0, 1, MSG_REJECT, 0, RJ, MSG_GET_SNK_CAP},
    '{SK, 1, 0, 1, 1, MSG_NOT_SUPP, 0, RJ, MSG_GET_SNK_CAP},
    '{SK, 1, 0, 1, 1, MSG_NONE, 0, TO, MSG_GET_SNK_CAP},
    '{SR, 0, 1, 1, 1, MSG_SRC_CAPS, 0, RJ, MSG_NONE},
    '{SR, 1, 1, 0, 1, MSG_SRC_CAPS, 7, OK, MSG_GET_SRC_CAP},
    '{SR, 0, 0, 1, 1, MSG_REJECT, 0, RJ, MSG_GET_SRC_CAP},
    '{SR, 0, 0, 1, 1, MSG_NOT_SUPP, 0, RJ, MSG_GET_SRC_CAP},
    '{SR, 0, 0, 1, 1, MSG_NONE, 0, TO, MSG_GET_SRC_CAP},
    '{SS, 1, 0, 0, 1, MSG_NONE, 0, RJ, MSG_NONE},
    '{SS, 0, 0, 1, 1, MSG_NONE, 0, OK, MSG_SRC_CAPS},
    '{SS, 0, 0, 1, 0, MSG_NONE, 0, TO, MSG_SRC_CAPS},
    '{32'h54657374, 0, 0, 1, 1, MSG_NONE, 0, `RC_UNKNOWN, MSG_NONE}};
  logic        clk, rst_n, task_valid, task_ready, task_done, src, ndrp, own;
  logic        pe_ready, hold_pe, ack_ok, goodcrc, no_ack, negotiate, early_tx, neg_seen;
  logic [31:0] task_code, caps_word, w;
  logic [7:0]  ret_code, caps_ofs, tx_cnt, c0, ret;
  logic [3:0]  ack_dly;
  logic [2:0]  nobj, caps_idx, src_cnt, snk_cnt;
  logic [15:0] salt;
  msg_t        reply, last_tx;
  tx_req_t     tx_req;
  rx_msg_t     rx_msg;
  rx_obj_t     rx_obj;
  row_t        r;
  int          err_count = 0;
  int          checks = 0;

  pd_cap_tasks #(.RESP_CYC(20), .NOBJ(7)) dut (
    .CLK(clk), .RST_N(rst_n), .TASK_VALID(task_valid), .TASK_CODE(task_code),
    .TASK_READY(task_ready), .TASK_DONE(task_done), .RET_CODE(ret_code),
    .PARTNER_IS_SRC(src), .PARTNER_NOT_DRP(ndrp), .OWN_ROLE_SRC(own),
    .PE_READY(pe_ready), .TX_REQ(tx_req), .TX_GOODCRC(goodcrc), .TX_NO_ACK(no_ack),
    .RX_MSG(rx_msg), .RX_OBJ(rx_obj), .NEGOTIATE_REQ(negotiate), .CAPS_OFS(caps_ofs),
    .CAPS_IDX(caps_idx), .CAPS_WORD(caps_word), .SRC_CAPS_CNT(src_cnt),
    .SNK_CAPS_CNT(snk_cnt));
  pd_link_model model (
    .clk(clk), .hold_pe(hold_pe), .ack_ok(ack_ok), .ack_dly(ack_dly), .reply(reply),
    .nobj(nobj), .salt(salt), .tx_req(tx_req), .pe_ready(pe_ready), .goodcrc(goodcrc),
    .no_ack(no_ack), .rx_msg(rx_msg), .rx_obj(rx_obj), .last_tx(last_tx),
    .tx_cnt(tx_cnt), .early_tx(early_tx));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (negotiate === 1'b1)
      neg_seen <= 1'b1;
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one task at a time: offer, then wait for completion
  task automatic offer(input logic [31:0] code);
    task_valid = 1'b1;
    task_code  = code;
    @(negedge clk);
    task_valid = 1'b0;
  endtask
  task automatic wait_done(output logic [7:0] rc);
    int n;
    n = 0;
    while (task_done !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 300)
      err_count++;
    rc = ret_code;
    @(negedge clk);
  endtask
  task automatic read_word(input logic [7:0] ofs, input logic [2:0] idx, output logic [31:0] d);
    caps_ofs = ofs;
    caps_idx = idx;
    @(negedge clk);
    d = caps_word;
  endtask
  task automatic idle_check();
    check("ready", task_ready, 1);
    check("ret", ret_code, 0);
    check("counts", {src_cnt, snk_cnt}, 0);
  endtask

  initial
  begin
    repeat (6000) @(posedge clk);
    err_count++;
    results();
  end

  initial
  begin
    rst_n = 0; task_valid = 0; task_code = '0; src = 0; ndrp = 0; own = 0;
    hold_pe = 0; ack_ok = 1; ack_dly = 0; reply = MSG_NONE; nobj = 0; salt = 0;
    caps_ofs = 8'h00; caps_idx = 3'h0; neg_seen = 0;
    repeat (20) @(negedge clk);
    idle_check();
    rst_n = 1;
    foreach (rows[i])
    begin
      r = rows[i];
      src = r.src; ndrp = r.ndrp; own = r.own; ack_ok = r.ack; reply = r.reply;
      nobj = r.n; salt = 16'h5a00 + 16'(i); ack_dly = 4'(i % 4 * 3);
      neg_seen = 0;
      c0 = tx_cnt;
      offer(r.code);
      wait_done(ret);
      check("ret_code", ret, r.ret);
      check("tx_count", tx_cnt - c0, (r.tx != MSG_NONE));
      if (r.tx != MSG_NONE)
        check("tx_kind", last_tx, r.tx);
      check("negotiate", neg_seen, (r.code == SS && r.ret == OK));
      if (r.n != 0)
      begin
        check("count", (r.tx == MSG_GET_SNK_CAP) ? snk_cnt : src_cnt, r.n);
        for (int k = 0; k < r.n; k++)
        begin
          read_word((r.tx == MSG_GET_SNK_CAP) ? `OFS_RX_SNK_CAPS : `OFS_RX_SRC_CAPS, k[2:0], w);
          check("caps_word", w, {salt, 13'h0000, k[2:0]});
        end
      end
    end
    read_word(8'h32, 3'h0, w);
    check("unmapped", w, 0);
    // stalled policy engine, and a task offered while busy
    src = 1; reply = MSG_SRC_CAPS; nobj = 1; ack_ok = 1; salt = 16'h1234; hold_pe = 1;
    c0 = tx_cnt;
    offer(SR);
    repeat (5) @(negedge clk);
    check("busy", task_ready, 0);
    offer(SS);
    hold_pe = 0;
    wait_done(ret);
    check("stall_ret", ret, OK);
    check("stall_tx", tx_cnt - c0, 1);
    check("early_tx", early_tx, 0);
    check("one_done", task_done, 0);
    check("src_cnt", src_cnt, 1);
    // reset while idle after the last task clears results
    rst_n = 0;
    repeat (2) @(negedge clk);
    idle_check();
    rst_n = 1;
    results();
  end
endmodule // test_pd_cap_tasks
